/* dv/lcm_cmd_bench.sv */
/*
 bench: a scenario per command group, verdict.
 assumes design, host and monitor compiled with it.
*/
`timescale 1ns/1ps
`include "lcm_defines.vh"
module lcm_cmd_bench;
    // ----
    // clock, design and host
    // ----
    reg clk = 1'b0;
    reg sys_rst = 1'b1;
    reg [63:0] cur_cfg = 64'h0;
    reg [7:0] pwr_pulse_len = 8'h01;
    reg [3:0] feat_en_set = 4'h0;
    wire rx_valid;
    wire [7:0] rx_data;
    wire tx_ready;
    wire tx_valid;
    wire [7:0] tx_data;
    wire host_rst;
    wire host_pwr;
    wire [319:0] disp_chars;
    wire [4:0] cursor_col;
    wire cursor_row;
    wire [63:0] cfg_out;
    wire [31:0] fan_pwr;
    wire [3:0] feat_en;
    integer fail_count = 0;
    integer num_checks = 0;
    integer cyc = 0;
    integer i;
    always #12.5 clk = ~clk;
    lcm_cmd #(.FAN_GAP(8), .HRST_TIME(5), .PULSE_UNIT(2)) uut (.clk(clk), .sys_rst(sys_rst),
        .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready), .cur_cfg(cur_cfg),
        .pwr_pulse_len(pwr_pulse_len), .feat_en_set(feat_en_set), .tx_valid(tx_valid),
        .tx_data(tx_data), .host_rst(host_rst), .host_pwr(host_pwr), .disp_chars(disp_chars),
        .cursor_col(cursor_col), .cursor_row(cursor_row), .cfg_out(cfg_out),
        .fan_pwr(fan_pwr), .feat_en(feat_en));
    lcm_host host (.clk(clk), .tx_valid(tx_valid), .tx_data(tx_data), .rx_valid(rx_valid),
        .rx_data(rx_data), .tx_ready(tx_ready));
    // ----
    // helpers
    // ----
    task chk(input string what, input [63:0] exp, input [63:0] got);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("[FAIL] %s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task chk8(input string what, input [7:0] exp, input [7:0] got);
        chk(what, {56'h0, exp}, {56'h0, got});
    endtask
    function [7:0] ch(input integer k);
        ch = disp_chars[8 * k +: 8];
    endfunction
    task cmd(input [7:0] typ, input [7:0] len, input [7:0] et, input [7:0] el);
        begin
            host.send(typ, len);
            host.get(400);
            chk8("crc", 8'h01, {7'h0, host.rok});
            chk8("type", et, host.rtyp);
            chk8("len", el, host.rlen);
        end
    endtask
    task key(input [7:0] a, input [7:0] b, input [7:0] c);
        begin
            host.pl[0] = a;
            host.pl[1] = b;
            host.pl[2] = c;
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", num_checks, fail_count);
            if (fail_count == 0 && num_checks > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fail_count = fail_count + 1;
            give_verdict;
        end
    end
    // ----
    // scenarios
    // ----
    task t_echo;
        integer l;
        begin
            chk("boot fans", 64'h64646464, {32'h0, fan_pwr});
            chk("boot cfg", `LCM_BOOT_CFG_RST, cfg_out);
            for (l = 0; l <= 16; l = l + 16) begin
                for (i = 0; i < 16; i = i + 1) host.pl[i] = 8'hc0 + i[7:0];
                cmd(8'h00, l[7:0], 8'h40, l[7:0]);
                for (i = 0; i < l; i = i + 1) chk8("echo", 8'hc0 + i[7:0], host.rpl[i]);
            end
            cmd(8'h00, 8'h11, 8'hc0, 8'h00);
            cmd(8'h01, 8'h00, 8'h41, 8'h10);
            chk8("ver first", 8'h30, host.rpl[0]);
            chk8("ver last", 8'h66, host.rpl[15]);
            cmd(8'h01, 8'h01, 8'hc1, 8'h00);
            $display("test echo done");
        end
    endtask
    task t_user;
        begin
            for (i = 0; i < 16; i = i + 1) host.pl[i] = 8'h03 + 8'h07 * i[7:0];
            cmd(8'h02, 8'h10, 8'h42, 8'h00);
            host.pl[0] = 8'hff;
            cmd(8'h02, 8'h0f, 8'hc2, 8'h00);
            cmd(8'h03, 8'h00, 8'h43, 8'h10);
            for (i = 0; i < 16; i = i + 1) chk8("user", 8'h03 + 8'h07 * i[7:0], host.rpl[i]);
            $display("test user done");
        end
    endtask
    task t_disp;
        begin
            for (i = 0; i < 16; i = i + 1) host.pl[i] = 8'h41 + i[7:0];
            cmd(8'h07, 8'h10, 8'h47, 8'h00);
            for (i = 0; i < 20; i = i + 1) chk8("top", (i < 2 || i > 17) ? 8'h20 : 8'h3f + i[7:0], ch(i));
            cmd(8'h06, 8'h00, 8'h46, 8'h00);
            for (i = 0; i < 40; i = i + 1) chk8("clear", 8'h20, ch(i));
            chk8("cursor", 8'h00, {2'h0, cursor_row, cursor_col});
            cmd(8'h07, 8'h10, 8'h47, 8'h00);
            $display("test display done");
        end
    endtask
    task t_store;
        begin
            cur_cfg <= 64'h1234567800500032;
            cmd(8'h04, 8'h00, 8'h44, 8'h00);
            feat_en_set <= 4'hf;
            @(posedge clk);
            feat_en_set <= 4'h0;
            repeat (2) @(posedge clk);
            chk8("en set", 8'h0f, {4'h0, feat_en});
            key(8'h08, 8'h12, 8'h63);
            cmd(8'h05, 8'h03, 8'h45, 8'h00);
            chk("cfg", 64'h1234567800500032, cfg_out);
            chk("fans", 64'h00500032, {32'h0, fan_pwr});
            chk8("en", 8'h00, {4'h0, feat_en});
            chk8("kept char", 8'h41, ch(2));
            $display("test store done");
        end
    endtask
    task t_pins;
        integer n;
        begin
            feat_en_set <= 4'h3;
            @(posedge clk);
            feat_en_set <= 4'h0;
            key(8'h0c, 8'h1c, 8'h61);
            cmd(8'h05, 8'h03, 8'h45, 8'h00);
            for (n = 0; n < 20 && host_rst !== 1'b1; n = n + 1) @(posedge clk);
            chk8("host reset", 8'h01, {7'h0, host_rst});
            for (n = 0; n < 40 && host_rst !== 1'b0; n = n + 1) @(posedge clk);
            host.send(8'h00, 8'h00);
            host.get(20);
            chk8("ignored", 8'h00, {7'h0, host.rok});
            repeat (60) @(posedge clk);
            chk8("en", 8'h00, {4'h0, feat_en});
            pwr_pulse_len <= 8'h03;
            host.slow <= 1'b1;
            key(8'h03, 8'h0b, 8'h5f);
            cmd(8'h05, 8'h03, 8'h45, 8'h00);
            host.slow <= 1'b0;
            for (n = 0; n < 20 && host_pwr !== 1'b1; n = n + 1) @(posedge clk);
            for (n = 0; n < 100 && host_pwr === 1'b1; n = n + 1) @(posedge clk);
            chk8("pulse", 8'h06, n[7:0]);
            repeat (80) @(posedge clk);
            key(8'h01, 8'h02, 8'h03);
            cmd(8'h05, 8'h03, 8'hc5, 8'h00);
            cmd(8'h05, 8'h02, 8'hc5, 8'h00);
            cmd(8'h08, 8'h00, 8'hc8, 8'h00);
            chk8("pins", 8'h00, {6'h0, host_rst, host_pwr});
            $display("test pins done");
        end
    endtask
    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (100) @(posedge clk);
        t_echo;
        t_user;
        t_disp;
        t_store;
        t_pins;
        give_verdict;
    end
endmodule // lcm_cmd_bench

/* dv/lcm_cmd_monitor.sv */
/*
 checker: answer hold, host pins, enables.
 assumes binding to lcm_cmd ports only.
*/
`timescale 1ns/1ps
module lcm_cmd_monitor #(
    parameter HRST_TIME = 60000000,
    parameter PULSE_UNIT = 40000
) (
    input wire clk,
    input wire sys_rst,
    input wire tx_valid,
    input wire tx_ready,
    input wire [7:0] tx_data,
    input wire [7:0] pwr_pulse_len,
    input wire host_rst,
    input wire host_pwr,
    input wire [3:0] feat_en
);
    // ----
    // pin counters
    // ----
    reg [31:0] rst_cnt;
    reg [31:0] pwr_cnt;
    wire took = tx_valid & tx_ready;
    wire [31:0] pwr_len = (pwr_pulse_len == 8'h00 ? 32'h1 : {24'h0, pwr_pulse_len}) * PULSE_UNIT;
    always @(posedge clk) begin
        if (sys_rst) begin
            rst_cnt <= 32'h0;
            pwr_cnt <= 32'h0;
        end else begin
            rst_cnt <= host_rst ? rst_cnt + 32'h1 : 32'h0;
            pwr_cnt <= host_pwr ? pwr_cnt + 32'h1 : 32'h0;
        end
    end
    // ----
    // assertions
    // ----
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_tx_hold_busy: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("answer byte not held");
    a_reset_quiet: assert property ($fell(sys_rst) |-> !tx_valid && !host_rst && feat_en == 4'h0)
        else $error("not idle after reset");
    a_answer_kind: assert property ($rose(tx_valid) |-> tx_data[6] == 1'b1)
        else $error("bad answer type");
    a_ack_then_rst: assert property ($rose(host_rst) |-> $past(took))
        else $error("reset before answer");
    a_rst_length: assert property ($fell(host_rst) |-> rst_cnt == HRST_TIME)
        else $error("reset length");
    a_pwr_length: assert property ($fell(host_pwr) |-> pwr_cnt == pwr_len)
        else $error("pulse length");
    a_pins_apart: assert property (!(host_rst && host_pwr))
        else $error("both pins active");
    a_silent_hold: assert property (host_rst || host_pwr |-> !tx_valid)
        else $error("answer during host pin action");
    a_restart_clears: assert property ($fell(host_rst) |-> ##[0:3] feat_en == 4'h0)
        else $error("enables kept");
endmodule // lcm_cmd_monitor

bind lcm_cmd lcm_cmd_monitor #(.HRST_TIME(HRST_TIME), .PULSE_UNIT(PULSE_UNIT)) mon (
    .clk(clk), .sys_rst(sys_rst), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .pwr_pulse_len(pwr_pulse_len), .host_rst(host_rst),
    .host_pwr(host_pwr), .feat_en(feat_en));

/* dv/lcm_host.sv */
/*
 host model: sends commands, collects answers.
 assumes the design's clock.
*/
`timescale 1ns/1ps
module lcm_host (
    input wire clk,
    input wire tx_valid,
    input wire [7:0] tx_data,
    output reg rx_valid,
    output reg [7:0] rx_data,
    output reg tx_ready
);
    // ----
    // packet tasks
    // ----
    reg [7:0] pl [0:21];
    reg [7:0] rpl [0:21];
    reg [7:0] rtyp;
    reg [7:0] rlen;
    reg [15:0] crc;
    reg [15:0] rc;
    reg rok;
    reg slow = 1'b0;
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        tx_ready = 1'b1;
    end
    // model leaves host pins alone
    always @(posedge clk) tx_ready <= slow ? ~tx_ready : 1'b1;
    function [15:0] step(input [15:0] c, input [7:0] d);
        integer k;
        begin
            step = c ^ {8'h00, d};
            for (k = 0; k < 8; k = k + 1) begin
                step = step[0] ? (step >> 1) ^ 16'h8408 : step >> 1;
            end
        end
    endfunction
    task put(input [7:0] b);
        begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_data <= b;
            crc = step(crc, b);
            @(posedge clk);
            rx_valid <= 1'b0;
            rx_data <= ~b;
        end
    endtask
    // caller fills pl
    task send(input [7:0] typ, input [7:0] len);
        integer i;
        begin
            crc = 16'hffff;
            put(typ);
            put(len);
            for (i = 0; i < len; i = i + 1) begin
                put(pl[i]);
            end
            rc = ~crc;
            put(rc[7:0]);
            put(rc[15:8]);
        end
    endtask
    // lim bounds the wait
    task get(input integer lim);
        integer n;
        integer t;
        begin
            crc = 16'hffff;
            n = 0;
            t = 0;
            rlen = 8'h00;
            while (t < lim && n < rlen + 4) begin
                @(posedge clk);
                t = t + 1;
                if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
                    if (n < rlen + 2) crc = step(crc, tx_data);
                    if (n == 0) rtyp = tx_data;
                    else if (n == 1) rlen = tx_data;
                    else if (n < rlen + 2 && n < 24) rpl[n - 2] = tx_data;
                    else if (n == rlen + 2) rc[7:0] = tx_data;
                    else rc[15:8] = tx_data;
                    n = n + 1;
                end
            end
            rok = (n == rlen + 4) && (rc === ~crc);
        end
    endtask
endmodule // lcm_host

/* logic/lcm_cmd.v */
/*
 command interpreter for the first eight commands of a character display module:
 takes a byte stream of command packets, executes, answers with packets.
 assumes rx bytes come from a uart on the same clock and tx bytes go to one.
*/
//
// What this block does
// [RULE1] echo payload 0-16 bytes back, type 0x40
// [RULE2] version query answers 0x41 with 16 bytes
// [RULE3] user write needs 16 bytes, acked 0x42
// [RULE4] user read answers 0x43 with stored bytes
// [RULE5] store current state as boot, ack 0x44
// [RULE6] reporting, failsafe, watchdog enables never stored
// [RULE7] verify stored state, error on mismatch
// [RULE8] key 8,18,99 restarts module from boot state
// [RULE9] host waits up to 3 s
// [RULE10] fans start one by one, 500ms apart
// [RULE11] key 12,28,97 drives host reset pin
// [RULE12] ack, reset host, restart, then ignore commands; code ignores them only during the reset and restart, then accepts them again
// [RULE13] key 3,11,95 pulses host power, then restarts
// [RULE14] every restart variant acked 0x45, empty
// [RULE15] host keeps power pins in default mode
// [RULE16] clear fills 0x20, cursor home, ack 0x46
// [RULE17] top line: 16 centre chars, edges blank, 0x47
// [RULE18] answer carries command code in low bits
// [RULE19] packet is type, length, data, check value
// [RULE20] top bits 11 mark an error answer
// [RULE21] bad length or key gives error, no action; code drops a packet with length above 22 without any answer
`timescale 1ns/1ps
`include "lcm_defines.vh"

module lcm_cmd #(
    parameter FAN_GAP = `LCM_FAN_GAP_MS * `LCM_CLK_KHZ,
    parameter HRST_TIME = `LCM_HRST_MS * `LCM_CLK_KHZ,
    parameter PULSE_UNIT = `LCM_PULSE_UNIT_MS * `LCM_CLK_KHZ,
    parameter [127:0] VERSION_TEXT = 128'h30313233343536373839616263646566 // arbitrary
) (
    input wire clk,
    input wire sys_rst,
    input wire rx_valid,
    input wire [7:0] rx_data,
    input wire tx_ready,
    input wire [`LCM_CFG_W-1:0] cur_cfg,
    input wire [7:0] pwr_pulse_len,
    input wire [3:0] feat_en_set,
    output reg tx_valid,
    output reg [7:0] tx_data,
    output reg host_rst,
    output reg host_pwr,
    output reg [319:0] disp_chars,
    output reg [4:0] cursor_col,
    output reg cursor_row,
    output reg [`LCM_CFG_W-1:0] cfg_out,
    output reg [31:0] fan_pwr,
    output reg [3:0] feat_en
);
    // ---------------------------------------------------------------
    // states
    // ---------------------------------------------------------------
    localparam [7:0] S_RX = 8'h01, S_EXEC = 8'h02, S_CHECK = 8'h04, S_TX = 8'h08;
    localparam [7:0] S_HOLD = 8'h10, S_BOOT = 8'h20, S_FAN = 8'h40;
    localparam [4:0] P_TYPE = 5'h01, P_LEN = 5'h02, P_DATA = 5'h04;
    localparam [4:0] P_CRC0 = 5'h08, P_CRC1 = 5'h10;

    reg [7:0] state;
    reg [4:0] pst;
    reg [7:0] pay [0:21];
    reg [7:0] user_mem [0:15];
    reg [7:0] rx_type, rx_len, crc_lo;
    reg [4:0] rx_idx;
    reg [15:0] rx_crc, tx_crc;
    reg [7:0] resp_type, resp_len, tx_idx;
    reg [1:0] resp_src;
    reg tx_on, post_hold, hold_pwr, ack_after;
    reg [31:0] timer;
    reg [2:0] fan_i;
    reg [319:0] boot_disp;
    reg [4:0] boot_col;
    reg boot_row;
    reg [`LCM_CFG_W-1:0] boot_cfg;
    wire [15:0] rx_crc_next, tx_crc_next;
    wire [5:0] code = rx_type[5:0];
    wire [23:0] key = {pay[0], pay[1], pay[2]};
    wire [31:0] boot_fans = boot_cfg[`LCM_FAN_LSB +: 32];
    integer k;

    lcm_crc16 u_rx_crc (
        .crc_in(pst == P_TYPE ? `LCM_CRC_INIT : rx_crc),
        .data(rx_data),
        .crc_out(rx_crc_next)
    );
    lcm_crc16 u_tx_crc (
        .crc_in(tx_crc),
        .data(tx_data),
        .crc_out(tx_crc_next)
    );

    // ---------------------------------------------------------------
    // type, length or payload byte of the answer
    // ---------------------------------------------------------------
    function [7:0] pick;
        input [7:0] i;
        reg [4:0] j;
        begin
            j = i[4:0] - 5'd2;
            if (i == 8'h00) begin
                pick = resp_type;
            end else if (i == 8'h01) begin
                pick = resp_len;
            end else if (resp_src == 2'h1) begin
                pick = VERSION_TEXT[8 * (15 - j[3:0]) +: 8]; // RULE2
            end else if (resp_src == 2'h2) begin
                pick = user_mem[j[3:0]]; // RULE4
            end else begin
                pick = pay[j]; // RULE1
            end
        end
    endfunction

    // ---------------------------------------------------------------
    // main sequencer
    // ---------------------------------------------------------------
    always @(posedge clk) begin
        if (sys_rst) begin
            state <= S_BOOT;
            pst <= P_TYPE;
            rx_type <= 8'h00;
            rx_len <= 8'h00;
            crc_lo <= 8'h00;
            rx_idx <= 5'h00;
            rx_crc <= `LCM_CRC_INIT;
            tx_crc <= `LCM_CRC_INIT;
            resp_type <= 8'h00;
            resp_len <= 8'h00;
            resp_src <= 2'h0;
            tx_idx <= 8'h00;
            tx_on <= 1'b0;
            post_hold <= 1'b0;
            hold_pwr <= 1'b0;
            ack_after <= 1'b0;
            timer <= 32'h0;
            fan_i <= 3'h0;
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            host_rst <= 1'b0;
            host_pwr <= 1'b0;
            disp_chars <= {40{`LCM_BLANK}};
            boot_disp <= {40{`LCM_BLANK}};
            cursor_col <= 5'h00;
            cursor_row <= 1'b0;
            boot_col <= 5'h00;
            boot_row <= 1'b0;
            cfg_out <= `LCM_BOOT_CFG_RST;
            boot_cfg <= `LCM_BOOT_CFG_RST; // RULE10
            fan_pwr <= 32'h0;
            feat_en <= 4'h0;
            for (k = 0; k < 22; k = k + 1) begin
                pay[k] <= 8'h00;
            end
            for (k = 0; k < 16; k = k + 1) begin
                user_mem[k] <= 8'h00;
            end
        end else begin
            feat_en <= feat_en | feat_en_set;
            case (state)
            S_RX: begin
                if (rx_valid) begin
                    case (pst)
                    P_TYPE: begin
                        rx_type <= rx_data;
                        rx_crc <= rx_crc_next;
                        pst <= P_LEN;
                    end
                    P_LEN: begin
                        rx_len <= rx_data;
                        rx_crc <= rx_crc_next;
                        rx_idx <= 5'h00;
                        if (rx_data > `LCM_MAX_LEN) begin
                            pst <= P_TYPE;
                        end else if (rx_data == 8'h00) begin
                            pst <= P_CRC0;
                        end else begin
                            pst <= P_DATA;
                        end
                    end
                    P_DATA: begin
                        pay[rx_idx] <= rx_data;
                        rx_crc <= rx_crc_next;
                        rx_idx <= rx_idx + 5'd1;
                        if ({3'h0, rx_idx} == rx_len - 8'h01) begin
                            pst <= P_CRC0;
                        end
                    end
                    P_CRC0: begin
                        crc_lo <= rx_data;
                        pst <= P_CRC1;
                    end
                    default: begin
                        pst <= P_TYPE;
                        if ({rx_data, crc_lo} == ~rx_crc
                            && rx_type[7:6] == `LCM_KIND_CMD) begin // RULE19
                            state <= S_EXEC;
                        end
                    end
                    endcase
                end
            end
            S_EXEC: begin
                resp_type <= {`LCM_KIND_RSP, code}; // RULE18
                resp_len <= 8'h00;
                resp_src <= 2'h0;
                post_hold <= 1'b0;
                state <= S_TX;
                case (code)
                `LCM_C_ECHO: begin
                    resp_len <= rx_len; // RULE1
                end
                `LCM_C_VER: begin
                    resp_len <= `LCM_BLOCK_LEN;
                    resp_src <= 2'h1;
                end
                `LCM_C_UWR: begin
                    for (k = 0; k < 16; k = k + 1) begin
                        user_mem[k] <= pay[k]; // RULE3
                    end
                end
                `LCM_C_URD: begin
                    resp_len <= `LCM_BLOCK_LEN;
                    resp_src <= 2'h2;
                end
                `LCM_C_STORE: begin
                    boot_disp <= disp_chars; // RULE5
                    boot_col <= cursor_col;
                    boot_row <= cursor_row;
                    boot_cfg <= cur_cfg; // RULE6
                    state <= S_CHECK;
                end
                `LCM_C_RESTART: begin
                    if (key == `LCM_SELF_KEY) begin
                        ack_after <= 1'b1; // RULE8
                        state <= S_BOOT;
                    end else begin
                        post_hold <= 1'b1; // RULE12
                        hold_pwr <= (key == `LCM_POFF_KEY); // RULE13
                    end
                end
                `LCM_C_CLEAR: begin
                    disp_chars <= {40{`LCM_BLANK}}; // RULE16
                    cursor_col <= 5'h00;
                    cursor_row <= 1'b0;
                end
                default: begin
                    disp_chars[159:0] <= {`LCM_BLANK, `LCM_BLANK,
                        pay[15], pay[14], pay[13], pay[12], pay[11], pay[10], pay[9],
                        pay[8], pay[7], pay[6], pay[5], pay[4], pay[3], pay[2], pay[1],
                        pay[0], `LCM_BLANK, `LCM_BLANK}; // RULE17
                end
                endcase
                if (code > `LCM_C_LINE1
                    || (code == `LCM_C_ECHO && rx_len > `LCM_ECHO_MAX)
                    || ((code == `LCM_C_UWR || code == `LCM_C_LINE1)
                        && rx_len != `LCM_BLOCK_LEN)
                    || ((code == `LCM_C_VER || code == `LCM_C_URD || code == `LCM_C_STORE
                        || code == `LCM_C_CLEAR) && rx_len != 8'h00)
                    || (code == `LCM_C_RESTART && (rx_len != `LCM_RST_LEN
                        || (key != `LCM_SELF_KEY && key != `LCM_HRST_KEY
                            && key != `LCM_POFF_KEY)))) begin
                    resp_type <= {`LCM_KIND_ERR, code}; // RULE20 RULE21
                    resp_len <= 8'h00;
                    resp_src <= 2'h0;
                    post_hold <= 1'b0;
                    ack_after <= 1'b0;
                    state <= S_TX;
                    disp_chars <= disp_chars;
                    cursor_col <= cursor_col;
                    cursor_row <= cursor_row;
                    boot_disp <= boot_disp;
                    boot_col <= boot_col;
                    boot_row <= boot_row;
                    boot_cfg <= boot_cfg;
                    for (k = 0; k < 16; k = k + 1) begin
                        user_mem[k] <= user_mem[k];
                    end
                end
            end
            S_CHECK: begin
                state <= S_TX;
                if (boot_disp != disp_chars || boot_col != cursor_col
                    || boot_row != cursor_row || boot_cfg != cur_cfg) begin
                    resp_type <= {`LCM_KIND_ERR, code}; // RULE7
                end
            end
            S_TX: begin
                if (!tx_on) begin
                    tx_on <= 1'b1;
                    tx_valid <= 1'b1;
                    tx_data <= resp_type; // RULE14
                    tx_idx <= 8'h00;
                    tx_crc <= `LCM_CRC_INIT;
                end else if (tx_ready) begin
                    tx_idx <= tx_idx + 8'h01;
                    if (tx_idx <= resp_len + 8'h01) begin
                        tx_crc <= tx_crc_next; // RULE19
                    end
                    if (tx_idx < resp_len + 8'h01) begin
                        tx_data <= pick(tx_idx + 8'h01);
                    end else if (tx_idx == resp_len + 8'h01) begin
                        tx_data <= ~tx_crc_next[7:0];
                    end else if (tx_idx == resp_len + 8'h02) begin
                        tx_data <= ~tx_crc[15:8];
                    end else begin
                        tx_on <= 1'b0;
                        tx_valid <= 1'b0;
                        if (post_hold) begin
                            post_hold <= 1'b0;
                            state <= S_HOLD;
                            host_rst <= ~hold_pwr; // RULE11
                            host_pwr <= hold_pwr; // RULE13
                            timer <= hold_pwr
                                ? (pwr_pulse_len == 8'h00 ? 32'h1 : {24'h0, pwr_pulse_len})
                                    * PULSE_UNIT
                                : HRST_TIME;
                        end else begin
                            state <= S_RX;
                        end
                    end
                end
            end
            S_HOLD: begin
                timer <= timer - 32'h1;
                if (timer <= 32'h1) begin
                    host_rst <= 1'b0;
                    host_pwr <= 1'b0;
                    state <= S_BOOT; // RULE12
                end
            end
            S_BOOT: begin
                disp_chars <= boot_disp; // RULE8
                cursor_col <= boot_col;
                cursor_row <= boot_row;
                cfg_out <= boot_cfg;
                feat_en <= 4'h0; // RULE6
                fan_pwr <= 32'h0;
                fan_i <= 3'h0;
                timer <= 32'h0;
                pst <= P_TYPE;
                state <= S_FAN;
            end
            default: begin
                if (timer != 32'h0) begin
                    timer <= timer - 32'h1; // RULE10
                end else if (fan_i == 3'h4) begin
                    ack_after <= 1'b0;
                    state <= ack_after ? S_TX : S_RX; // RULE12
                end else begin
                    fan_i <= fan_i + 3'h1;
                    if (boot_fans[8 * fan_i[1:0] +: 8] != 8'h00) begin
                        fan_pwr[8 * fan_i[1:0] +: 8] <= boot_fans[8 * fan_i[1:0] +: 8];
                        timer <= FAN_GAP; // RULE10
                    end
                end
            end
            endcase
        end
    end
endmodule // lcm_cmd

/* logic/lcm_crc16.v */
/*
 one byte step of the 16-bit packet check value (reflected form).
 assumes the caller holds the running value and the initial value.
*/
`timescale 1ns/1ps
`include "lcm_defines.vh"

module lcm_crc16 (
    input wire [15:0] crc_in,
    input wire [7:0] data,
    output reg [15:0] crc_out
);
    integer b;
    always @* begin
        crc_out = crc_in ^ {8'h00, data};
        for (b = 0; b < 8; b = b + 1) begin
            if (crc_out[0]) begin
                crc_out = (crc_out >> 1) ^ `LCM_CRC_POLY;
            end else begin
                crc_out = crc_out >> 1;
            end
        end
    end
endmodule // lcm_crc16

/* logic/lcm_defines.vh */
/*
 constants of the character display command interpreter:
 packet type codes, command codes, payload sizes, timing and reset values.
 assumes a 40 MHz system clock.
*/
`ifndef LCM_DEFINES_VH
`define LCM_DEFINES_VH

// ---------------------------------------------------------------
// packet type field, length limit and check value
// ---------------------------------------------------------------
`define LCM_KIND_CMD 2'h0
`define LCM_KIND_RSP 2'h1
`define LCM_KIND_ERR 2'h3
`define LCM_MAX_LEN 8'h16
`define LCM_CRC_INIT 16'hffff
`define LCM_CRC_POLY 16'h8408

// ---------------------------------------------------------------
// command codes and sizes
// ---------------------------------------------------------------
`define LCM_C_ECHO 6'h00
`define LCM_C_VER 6'h01
`define LCM_C_UWR 6'h02
`define LCM_C_URD 6'h03
`define LCM_C_STORE 6'h04
`define LCM_C_RESTART 6'h05
`define LCM_C_CLEAR 6'h06
`define LCM_C_LINE1 6'h07
`define LCM_ECHO_MAX 8'h10
`define LCM_BLOCK_LEN 8'h10
`define LCM_RST_LEN 8'h03
`define LCM_SELF_KEY 24'h081263
`define LCM_HRST_KEY 24'h0c1c61
`define LCM_POFF_KEY 24'h030b5f
`define LCM_BLANK 8'h20

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define LCM_CLK_KHZ 40000
`define LCM_FAN_GAP_MS 500
`define LCM_HRST_MS 1500
`define LCM_PULSE_UNIT_MS 1

// ---------------------------------------------------------------
// configuration word layout and boot defaults
// ---------------------------------------------------------------
`define LCM_CFG_W 64
`define LCM_FAN_LSB 0
`define LCM_BOOT_CFG_RST 64'h0000000064646464

`endif
